// ---- logic/adcdc_pkg.sv ----
// shared constants and state types of the cascaded converter readout
package adcdc_pkg;
  // ----------------------------------------
  // word format
  // ----------------------------------------
  localparam int WORD_BITS = 24;
  localparam int CNT_W     = 16;
  // ----------------------------------------
  // settling in conversion clock periods
  // ----------------------------------------
  localparam int SETTLE_DEC8  = 594;
  localparam int SETTLE_DEC16 = 1186;
  localparam int SETTLE_DEC32 = 2370;
  localparam int SETTLE_FIXED = 4;
  // ----------------------------------------
  // host timing on clk_sys
  // ----------------------------------------
  localparam int SYS_CLK_MHZ      = 50;
  localparam int CONV_HALF        = 2;
  localparam int SHIFT_HALF       = 16;
  localparam int SYNC_LOW_NS      = 400;
  localparam int SYNC_LOW_CYC     = (SYNC_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int READY_LEAD_NS    = 100;
  localparam int READY_LEAD_CYC   = (READY_LEAD_NS * SYS_CLK_MHZ + 999) / 1000;
  // ----------------------------------------
  // device output frame in conversion periods
  // ----------------------------------------
  localparam int OUT_PERIOD = 1024;
  localparam int READY_LOW  = 960;

  function automatic int settle_conv(input int decim);
    if (decim == 8) begin
      return SETTLE_DEC8 + SETTLE_FIXED;
    end else if (decim == 16) begin
      return SETTLE_DEC16 + SETTLE_FIXED;
    end
    return SETTLE_DEC32 + SETTLE_FIXED;
  endfunction

  typedef enum logic [2:0] {
    ADCDC_D_PDOWN  = 3'h0,
    ADCDC_D_EXIT   = 3'h1,
    ADCDC_D_FRESET = 3'h2,
    ADCDC_D_SETTLE = 3'h3,
    ADCDC_D_LOW    = 3'h4,
    ADCDC_D_HIGH   = 3'h5
  } adcdc_dev_state_t;

  typedef enum logic [2:0] {
    ADCDC_H_IDLE   = 3'h0,
    ADCDC_H_SYNC   = 3'h1,
    ADCDC_H_SETTLE = 3'h2,
    ADCDC_H_WAIT   = 3'h3,
    ADCDC_H_LEAD   = 3'h4,
    ADCDC_H_SHIFT  = 3'h5,
    ADCDC_H_DRAIN  = 3'h6
  } adcdc_host_state_t;
endpackage

// ---- logic/adcdc_if.sv ----
// link between host controller and chain-head converter
`timescale 1ns/1ps
interface adcdc_if;
  logic conv_clk;
  logic shift_clk;
  logic select_n;
  logic sync_powerdown_n;
  logic result_ready_n;
  logic serial_out;
  logic serial_out_oe;
  logic chain_in;
  logic sdo_line;

  // undriven line reads low, as with a weak pull-down
  assign sdo_line = serial_out_oe & serial_out;

  modport dev (
    input  conv_clk,
    input  shift_clk,
    input  select_n,
    input  sync_powerdown_n,
    input  chain_in,
    output result_ready_n,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output conv_clk,
    output shift_clk,
    output select_n,
    output sync_powerdown_n,
    input  result_ready_n,
    input  sdo_line
  );
endinterface

// ---- logic/adcdc_shifter.sv ----
// output shift register of one converter
`timescale 1ns/1ps
module adcdc_shifter #(
  parameter int W = adcdc_pkg::WORD_BITS
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_word,
  input  wire logic         shift,
  input  wire logic         shift_bit,
  // serial side
  output logic              msb
);
  logic [W-1:0] sr;

  // --------------------------------------
  // load wins over shift
  // --------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr <= '0;
    // [R16] load then shift
    end else if (load) begin
      sr <= load_word;
    // [R1] shift register action
    end else if (shift) begin
      sr <= {sr[W-2:0], shift_bit};
    end
  end

  // [R12] msb first out
  assign msb = sr[W-1];
endmodule // adcdc_shifter

// ---- logic/adcdc_device.sv ----
// converter end: power-down, settling, ready frame and chain output
`timescale 1ns/1ps
module adcdc_device #(
  parameter int DECIM      = 8,
  parameter int OUT_PERIOD = adcdc_pkg::OUT_PERIOD,
  parameter int READY_LOW  = adcdc_pkg::READY_LOW
) (
  // reset, conversion clock comes on the link
  input  wire logic                           resetn,
  // link
  adcdc_if.dev                                link,
  // user side
  input  wire logic [adcdc_pkg::WORD_BITS-1:0] sample_in,
  output logic                                powered_down,
  output logic                                result_loaded
);
  localparam int CW = adcdc_pkg::CNT_W;
  // [R15] pin sync, exit and filter reset stages eat four periods
  localparam logic [CW-1:0] SETTLE_N = CW'(adcdc_pkg::settle_conv(DECIM) - 5);
  localparam logic [CW-1:0] LOW_N    = CW'(READY_LOW - 1);
  localparam logic [CW-1:0] HIGH_N   = CW'(OUT_PERIOD - READY_LOW - 1);

  adcdc_pkg::adcdc_dev_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [1:0] s_shift, s_sel, s_sync, s_chain;
  logic shift_q;
  logic ready_n;

  // --------------------------------------
  // pin synchronisers
  // --------------------------------------
  always_ff @(posedge link.conv_clk or negedge resetn) begin
    if (!resetn) begin
      s_shift <= 2'h3;
      s_sel   <= 2'h3;
      s_sync  <= 2'h3;
      s_chain <= 2'h0;
      shift_q <= 1'b1;
    end else begin
      s_shift <= {s_shift[0], link.shift_clk};
      s_sel   <= {s_sel[0], link.select_n};
      s_sync  <= {s_sync[0], link.sync_powerdown_n};
      s_chain <= {s_chain[0], link.chain_in};
      shift_q <= s_shift[1];
    end
  end

  wire shift_fall = shift_q & ~s_shift[1];
  wire sync_low   = ~s_sync[1];
  wire cnt_done   = (cnt == '0);
  wire enter_low  = (state == adcdc_pkg::ADCDC_D_SETTLE && cnt_done) ||
                    (state == adcdc_pkg::ADCDC_D_HIGH && cnt_done);

  // --------------------------------------
  // sequencing
  // --------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt - CW'(1);
    case (state)
      adcdc_pkg::ADCDC_D_PDOWN: begin
        next_cnt = cnt;
        if (!sync_low) begin
          next_state = adcdc_pkg::ADCDC_D_EXIT;
        end
      end
      adcdc_pkg::ADCDC_D_EXIT: begin
        next_state = adcdc_pkg::ADCDC_D_FRESET;
      end
      adcdc_pkg::ADCDC_D_FRESET: begin
        // [R15] settling count
        next_state = adcdc_pkg::ADCDC_D_SETTLE;
        next_cnt   = SETTLE_N;
      end
      adcdc_pkg::ADCDC_D_SETTLE, adcdc_pkg::ADCDC_D_HIGH: begin
        if (cnt_done) begin
          next_state = adcdc_pkg::ADCDC_D_LOW;
          next_cnt   = LOW_N;
        end
      end
      adcdc_pkg::ADCDC_D_LOW: begin
        if (cnt_done) begin
          next_state = adcdc_pkg::ADCDC_D_HIGH;
          next_cnt   = HIGH_N;
        end
      end
      default: begin
        next_state = adcdc_pkg::ADCDC_D_PDOWN;
      end
    endcase
    // [R14] power down on low
    if (sync_low) begin
      next_state = adcdc_pkg::ADCDC_D_PDOWN;
      next_cnt   = '0;
    end
  end

  always_ff @(posedge link.conv_clk or negedge resetn) begin
    if (!resetn) begin
      state   <= adcdc_pkg::ADCDC_D_PDOWN;
      cnt     <= '0;
      ready_n <= 1'b1;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      // [R6] ready stays high while settling
      ready_n <= (next_state != adcdc_pkg::ADCDC_D_LOW);
    end
  end

  wire load_now = enter_low & ~sync_low;

  // [R2] chain bits pass through
  adcdc_shifter #(
    .W (adcdc_pkg::WORD_BITS)
  ) u_shifter (
    .clk       (link.conv_clk),
    .resetn    (resetn),
    .load      (load_now),
    .load_word (sample_in),
    .shift     (shift_fall),
    .shift_bit (s_chain[1]),
    .msb       (link.serial_out)
  );

  // [R13] output gated by select
  assign link.serial_out_oe = ~s_sel[1];
  // [R7] own word leads the stream
  assign link.result_ready_n = ready_n;
  assign powered_down  = (state == adcdc_pkg::ADCDC_D_PDOWN);
  assign result_loaded = load_now;
endmodule // adcdc_device

// ---- logic/adcdc_host.sv ----
// host controller: clocks, sync pulse and cascaded result collection
//
// Summary of operation
// [R1] each device shifts out on falling edges
// [R2] results pass device to device to head
// [R3] last device chain input tied low
// [R4] one shared set of control lines
// [R5] common sync pulse before reading
// [R6] ignore output until settling has elapsed
// [R7] head word first, then chain order
// [R8] shift only while head ready low
// [R9] exactly 24 times K falling edges
// [R10] shift period fits window, select low
// [R11] select delays also fit the window
// [R12] 24-bit twos complement, msb first
// [R13] output tristated while select high
// [R14] sync low powers down, staged restart
// [R15] settling 594, 1186 or 2370 periods
// [R16] load on ready fall, shift in chain
`timescale 1ns/1ps
module adcdc_host #(
  parameter int NUM_DEV     = 4,
  parameter int DECIM       = 8,
  parameter bit USE_SELECT  = 1'b1,
  parameter int SETTLE_WAIT =
    adcdc_pkg::settle_conv(32) * 2 * adcdc_pkg::CONV_HALF
) (
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  // link
  adcdc_if.host                                link,
  // user side
  input  wire logic                            start,
  output logic                                 busy,
  output logic                                 word_valid,
  output logic [adcdc_pkg::WORD_BITS-1:0]      word_data,
  output logic [7:0]                           word_index,
  output logic                                 frame_error
);
  localparam int WB = adcdc_pkg::WORD_BITS;
  localparam int CW = adcdc_pkg::CNT_W;
  localparam int BW = 16;
  localparam logic [BW-1:0] TOTAL_BITS = BW'(WB * NUM_DEV);
  localparam logic [4:0] LAST_BIT = 5'(WB - 1);
  localparam logic [3:0] CONV_N  = 4'(adcdc_pkg::CONV_HALF - 1);
  // [R10] [R11] period fits window
  localparam logic [CW-1:0] HALF_N = CW'(adcdc_pkg::SHIFT_HALF - 1);
  localparam logic [CW-1:0] SYNC_N = CW'(adcdc_pkg::SYNC_LOW_CYC - 1);
  localparam logic [CW-1:0] LEAD_N = CW'(adcdc_pkg::READY_LEAD_CYC - 1);
  localparam int SW = $clog2(SETTLE_WAIT + 1);
  localparam logic [SW-1:0] SETTLE_N = SW'(SETTLE_WAIT - 1);

  // idle select level: high when used, tied low otherwise
  localparam logic SEL_IDLE = USE_SELECT;

  // --------------------------------------
  // registers
  // --------------------------------------
  adcdc_pkg::adcdc_host_state_t state, next_state;
  logic [3:0]    conv_cnt;
  logic          conv_q;
  logic [CW-1:0] cnt, next_cnt;
  logic [SW-1:0] wait_cnt, next_wait_cnt;
  logic [BW-1:0] bit_cnt, next_bit_cnt;
  logic          shift_int, next_shift_int;
  logic          sel_int, next_sel_int;
  logic          sync_int, next_sync_int;
  logic          shift_q, sel_q, sync_q;
  logic [1:0]    s_ready, s_sdo;
  logic [WB-1:0] word_sr;
  logic [4:0]    bit_pos;
  logic [7:0]    word_cnt;
  logic          abort;

  // --------------------------------------
  // conversion clock divider
  // --------------------------------------
  wire conv_flip = (conv_cnt == CONV_N);
  // pins move only as the conversion clock falls, so the devices
  // never see a control pin change at their sampling edge
  wire tick      = conv_flip & conv_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_cnt <= 4'h0;
      conv_q   <= 1'b0;
    end else begin
      conv_cnt <= conv_flip ? 4'h0 : conv_cnt + 4'h1;
      conv_q   <= conv_q ^ conv_flip;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 1'b1;
      sel_q   <= 1'b1;
      sync_q  <= 1'b1;
    end else begin
      shift_q <= tick ? shift_int : shift_q;
      sel_q   <= tick ? sel_int : sel_q;
      sync_q  <= tick ? sync_int : sync_q;
    end
  end

  // --------------------------------------
  // link input synchronisers
  // --------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_ready <= 2'h3;
      s_sdo   <= 2'h0;
    end else begin
      s_ready <= {s_ready[0], link.result_ready_n};
      s_sdo   <= {s_sdo[0], link.sdo_line};
    end
  end

  wire          ready_low  = ~s_ready[1];
  wire          sdo_bit    = s_sdo[1];
  wire          cnt_done   = (cnt == '0);
  wire          wait_done  = (wait_cnt == '0);
  wire          all_bits   = (bit_cnt == TOTAL_BITS);
  wire          start_new  = (state == adcdc_pkg::ADCDC_H_IDLE) && start;
  wire          frame_go   = (state == adcdc_pkg::ADCDC_H_WAIT) && ready_low;
  wire          sample_now = (state == adcdc_pkg::ADCDC_H_SHIFT) && cnt_done && shift_int;
  wire          word_end   = sample_now && (bit_pos == LAST_BIT);
  wire [WB-1:0] word_next  = {word_sr[WB-2:0], sdo_bit};

  // --------------------------------------
  // sequencing
  // --------------------------------------
  always_comb begin
    next_state     = state;
    next_cnt       = cnt_done ? cnt : cnt - CW'(1);
    next_wait_cnt  = wait_done ? wait_cnt : wait_cnt - SW'(1);
    next_bit_cnt   = bit_cnt;
    next_shift_int = shift_int;
    next_sel_int   = sel_int;
    next_sync_int  = sync_int;
    abort          = 1'b0;
    case (state)
      adcdc_pkg::ADCDC_H_IDLE: begin
        next_shift_int = 1'b1;
        next_sel_int   = SEL_IDLE;
        next_sync_int  = 1'b1;
        // [R5] common sync pulse
        if (start) begin
          next_state    = adcdc_pkg::ADCDC_H_SYNC;
          next_cnt      = SYNC_N;
          next_sync_int = 1'b0;
        end
      end
      adcdc_pkg::ADCDC_H_SYNC: begin
        // [R14] hold until ready high
        if (cnt_done && !ready_low) begin
          next_state    = adcdc_pkg::ADCDC_H_SETTLE;
          next_cnt      = HALF_N;
          next_sync_int = 1'b1;
        end
      end
      adcdc_pkg::ADCDC_H_SETTLE: begin
        // [R6] release must reach devices first
        if (cnt_done) begin
          next_state    = adcdc_pkg::ADCDC_H_WAIT;
          next_wait_cnt = SETTLE_N;
        end
      end
      adcdc_pkg::ADCDC_H_WAIT: begin
        if (ready_low) begin
          next_state   = adcdc_pkg::ADCDC_H_LEAD;
          next_cnt     = LEAD_N;
          next_sel_int = 1'b0;
          next_bit_cnt = '0;
        end else if (wait_done) begin
          next_state = adcdc_pkg::ADCDC_H_IDLE;
          abort      = 1'b1;
        end
      end
      adcdc_pkg::ADCDC_H_LEAD: begin
        if (cnt_done) begin
          next_state     = adcdc_pkg::ADCDC_H_SHIFT;
          next_cnt       = HALF_N;
          next_shift_int = 1'b1;
        end
      end
      adcdc_pkg::ADCDC_H_SHIFT: begin
        if (cnt_done) begin
          next_cnt = HALF_N;
          // [R9] one falling edge per bit
          if (shift_int) begin
            next_shift_int = 1'b0;
            next_bit_cnt   = bit_cnt + BW'(1);
          end else begin
            next_shift_int = 1'b1;
            if (all_bits) begin
              next_state = adcdc_pkg::ADCDC_H_DRAIN;
            end
          end
        end
        // [R8] window closed too early
        if (!ready_low) begin
          next_state     = adcdc_pkg::ADCDC_H_DRAIN;
          next_shift_int = 1'b1;
          abort          = 1'b1;
        end
      end
      adcdc_pkg::ADCDC_H_DRAIN: begin
        next_sel_int   = SEL_IDLE;
        next_shift_int = 1'b1;
        if (!ready_low) begin
          next_state = adcdc_pkg::ADCDC_H_IDLE;
        end
      end
      default: begin
        next_state = adcdc_pkg::ADCDC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state     <= adcdc_pkg::ADCDC_H_IDLE;
      cnt       <= '0;
      wait_cnt  <= '0;
      bit_cnt   <= '0;
      shift_int <= 1'b1;
      sel_int   <= SEL_IDLE;
      sync_int  <= 1'b1;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      wait_cnt  <= next_wait_cnt;
      bit_cnt   <= next_bit_cnt;
      shift_int <= next_shift_int;
      sel_int   <= next_sel_int;
      sync_int  <= next_sync_int;
    end
  end

  // --------------------------------------
  // word assembly
  // --------------------------------------
  // bit taken at the end of the high half, well after the last shift
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_sr <= '0;
      bit_pos <= 5'h00;
    end else begin
      word_sr <= sample_now ? word_next : word_sr;
      bit_pos <= (frame_go | word_end) ? 5'h00 : bit_pos + {4'h0, sample_now};
    end
  end

  // [R7] index follows chain order
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_cnt    <= 8'h00;
      word_valid  <= 1'b0;
      word_data   <= '0;
      word_index  <= 8'h00;
      frame_error <= 1'b0;
    end else begin
      word_cnt    <= frame_go ? 8'h00 : word_cnt + {7'h00, word_end};
      word_valid  <= word_end;
      word_data   <= word_end ? word_next : word_data;
      word_index  <= word_end ? word_cnt : word_index;
      // a fresh error wins over the clear at start
      frame_error <= abort | (frame_error & ~start_new);
    end
  end

  // --------------------------------------
  // link outputs
  // --------------------------------------
  // [R4] one shared control set
  assign link.conv_clk         = conv_q;
  assign link.shift_clk        = shift_q;
  assign link.select_n         = sel_q;
  assign link.sync_powerdown_n = sync_q;
  assign busy                  = (state != adcdc_pkg::ADCDC_H_IDLE);
endmodule // adcdc_host

// ---- verif/adcdc_props.sv ----
// assertions on the head link of the cascade
`timescale 1ns/1ps
module adcdc_props #(
  parameter int NUM_DEV = 2,
  parameter int SETTLE  = 594
) (
  // reset
  input wire logic resetn,
  // link
  input wire logic conv_clk,
  input wire logic shift_clk,
  input wire logic select_n,
  input wire logic sync_powerdown_n,
  input wire logic result_ready_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic chain_in
);
  logic        shift_q;
  logic        armed;
  logic [7:0]  fall_cnt;
  logic [11:0] settle_cnt;
  wire         fall = shift_q & ~shift_clk;
  // shift edges seen on conv_clk: both come from one divider, so none is missed
  always_ff @(posedge conv_clk or negedge resetn) begin
    if (!resetn) begin
      {shift_q, armed, fall_cnt, settle_cnt} <= '0;
    end else begin
      shift_q    <= shift_clk;
      armed      <= ~sync_powerdown_n | (armed & result_ready_n);
      fall_cnt   <= result_ready_n ? 8'h00 : fall_cnt + {7'h00, fall};
      settle_cnt <= sync_powerdown_n ? settle_cnt + {11'h000, ~&settle_cnt} : 12'h000;
    end
  end
  default clocking @(posedge conv_clk); endclocking
  default disable iff (!resetn);
  // select passes two sync stages before gating the output
  property p_tristate;
    select_n && $past(select_n) && $past(select_n, 2) |-> !serial_out_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("driven while deselected");
  property p_pdown; !sync_powerdown_n [*4] |-> result_ready_n; endproperty
  a_pdown: assert property (p_pdown) else $error("ready low in power-down");
  property p_hold; $rose(sync_powerdown_n) && armed |-> result_ready_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("ready fell early");
  property p_settle;
    $fell(result_ready_n) && armed |-> settle_cnt >= SETTLE && settle_cnt <= SETTLE + 8;
  endproperty
  a_settle: assert property (p_settle) else $error("settling length wrong");
  property p_bound; $rose(sync_powerdown_n) && armed |-> ##[1:700] !result_ready_n; endproperty
  a_bound: assert property (p_bound) else $error("no first result");
  property p_idle; result_ready_n && $past(result_ready_n) |-> !fall; endproperty
  a_idle: assert property (p_idle) else $error("shift outside window");
  property p_count; $rose(result_ready_n) && fall_cnt != 0 |-> fall_cnt == 24 * NUM_DEV; endproperty
  a_count: assert property (p_count) else $error("shift edge count wrong");
  property p_chain;
    @(negedge shift_clk) !result_ready_n && fall_cnt > 25 |-> serial_out == $past(chain_in, 24);
  endproperty
  a_chain: assert property (p_chain) else $error("chain bit lost");
  c_settle: cover property ($fell(result_ready_n) && armed);
  c_count: cover property ($rose(result_ready_n) && fall_cnt != 0);
  c_pdown: cover property ($fell(sync_powerdown_n));
endmodule // adcdc_props

// ---- verif/tb.sv ----
// self-checking bench for a two-device cascade
`timescale 1ns/1ps
module tb;
  localparam int K = 2;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        start   = 1'b0;
  logic        busy, word_valid, frame_error, pd0, pd1, ld0;
  logic        ld_seen = 1'b0;
  logic [23:0] word_data, s0, s1;
  logic [7:0]  word_index;
  logic [47:0] wire_bits, wire_q[$];
  logic [31:0] exp_q[$];
  int          fail_count = 0;
  int          n_checks = 0;
  int          wire_n = 0;
  always #10 clk_sys = ~clk_sys;
  // ----
  // chain
  // ----
  adcdc_if link0 ();
  adcdc_if link1 ();
  assign link1.conv_clk = link0.conv_clk;
  assign link1.shift_clk = link0.shift_clk;
  assign link1.select_n = link0.select_n;
  assign link1.sync_powerdown_n = link0.sync_powerdown_n;
  assign link0.chain_in = link1.sdo_line;
  assign link1.chain_in = 1'b0;
  adcdc_host #(.NUM_DEV(K)) i_adcdc_host (.clk_sys(clk_sys), .resetn(resetn), .link(link0.host),
    .start(start), .busy(busy), .word_valid(word_valid), .word_data(word_data),
    .word_index(word_index), .frame_error(frame_error));
  adcdc_device i_adcdc_device_0 (.resetn(resetn), .link(link0.dev), .sample_in(s0),
    .powered_down(pd0), .result_loaded(ld0));
  adcdc_device i_adcdc_device_1 (.resetn(resetn), .link(link1.dev), .sample_in(s1),
    .powered_down(pd1), .result_loaded());
  adcdc_props #(.NUM_DEV(K), .SETTLE(adcdc_pkg::SETTLE_DEC8)) i_adcdc_props (.resetn(resetn),
    .conv_clk(link0.conv_clk), .shift_clk(link0.shift_clk), .select_n(link0.select_n),
    .sync_powerdown_n(link0.sync_powerdown_n), .result_ready_n(link0.result_ready_n),
    .serial_out(link0.serial_out), .serial_out_oe(link0.serial_out_oe),
    .chain_in(link0.chain_in));
  // ----
  // checking
  // ----
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(negedge clk_sys) begin
    if (word_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("extra word", 48'h1, 48'h0);
      end else begin
        check("word", {16'h0, word_index, word_data}, {16'h0, exp_q.pop_front()});
      end
    end
  end
  // load strobe seen in the frame
  always @(negedge link0.conv_clk) begin
    if (ld0 === 1'b1) begin
      ld_seen = 1'b1;
    end
  end
  // bit read before the edge moves it
  always @(negedge link0.shift_clk) begin
    if (link0.result_ready_n === 1'b0) begin
      wire_bits = {wire_bits[46:0], link0.sdo_line};
      wire_n++;
    end
  end
  always @(posedge link0.result_ready_n) begin
    if (wire_n != 0) begin
      check("edge count", 48'(wire_n), 48'(24 * K));
      check("wire bits", wire_bits, wire_q.size() ? wire_q.pop_front() : 48'h0);
      check("load strobe", 48'(ld_seen), 48'h1);
    end
    wire_n = 0;
    ld_seen = 1'b0;
  end
  // ----
  // stimulus
  // ----
  task automatic run_frame(input logic [23:0] a, input logic [23:0] b);
    int i;
    s0 = a;
    s1 = b;
    exp_q.push_back({8'h00, a});
    exp_q.push_back({8'h01, b});
    wire_q.push_back({a, b});
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    for (i = 0; i < 20000 && (exp_q.size() || wire_q.size() || busy !== 1'b0); i++) begin
      @(negedge clk_sys);
    end
    check("finished", 48'(i < 20000), 48'h1);
    check("flags", {45'h0, frame_error, pd0, pd1}, 48'h0);
    $display("test done %h %h", a, b);
  endtask
  initial begin
    s0 = 24'h0;
    s1 = 24'h0;
    void'($urandom(80));
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    run_frame(24'h800000, 24'h7fffff);
    run_frame(24'hffffff, 24'h000001);
    repeat (2) run_frame(24'($urandom), 24'($urandom));
    complete_run();
  end
  // each run is a sync, settling and one frame; allow well over four of them
  initial begin
    #(95000 * 20);
    fail_count++;
    complete_run();
  end
endmodule // tb
